/* File: rtl/tbsl_pkg.sv */
// Purpose: shared constants for the tile boot and security loader
// Assumes: 100 MHz system clock, 32-bit Avalon-MM register bus
// Notes:   offsets are byte addresses of aligned words
package tbsl_pkg;
   // clock and timing
   localparam int CLK_PERIOD_NS   = 10;
   localparam int BOOT_DELAY_NS   = 15000;
   localparam int BOOT_DELAY_CYC  = (BOOT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DLY_W           = 12;

   // register map
   localparam logic [5:0] REG_PLL_CFG   = 6'h00;
   localparam logic [5:0] REG_SECURITY  = 6'h04;
   localparam logic [5:0] REG_STATUS    = 6'h08;
   localparam logic [5:0] REG_OTP_ADDR  = 6'h0C;
   localparam logic [5:0] REG_OTP_DATA  = 6'h10;
   localparam logic [5:0] REG_OTP_CTRL  = 6'h14;
   localparam logic [5:0] REG_CRC       = 6'h18;
   localparam logic [5:0] REG_RATIO     = 6'h1C;

   // pll configuration fields
   localparam int PLL_IN_LSB   = 0;
   localparam int PLL_IN_W     = 6;
   localparam int PLL_FB_LSB   = 8;
   localparam int PLL_FB_W     = 12;
   localparam int PLL_POST_LSB = 20;
   localparam int PLL_POST_W   = 3;
   localparam logic [5:0]  PLL_IN_RST   = 6'h00;
   localparam logic [11:0] PLL_FB_RST   = 12'h03F;
   localparam logic [2:0]  PLL_POST_RST = 3'h1;

   // security register bits
   localparam int SEC_NO_TEST     = 0;
   localparam int SEC_NO_LINK     = 1;
   localparam int SEC_OTP_BOOT    = 5;
   localparam int SEC_REDUNDANT   = 7;
   localparam int SEC_LOCK_LSB    = 8;
   localparam int SEC_MASTER_LOCK = 12;
   localparam int SEC_NO_TEST_OTP = 13;
   localparam int SEC_GP_LSB      = 15;
   localparam int SEC_GP_MSB      = 21;
   localparam int SEC_UID_LSB     = 22;
   localparam int SEC_UID_MSB     = 31;
   localparam logic [31:0] SEC_RST = 32'h0000_0000;
   localparam logic [31:0] SEC_SW_MASK = 32'h003F_8000;

   // otp organisation and programming control
   localparam int OTP_ROW_W      = 9;
   localparam int OTP_SECTORS    = 4;
   localparam logic [15:0] OTP_SEC_ROW = 16'h0800;
   localparam int OTP_CTRL_ROW   = 0;
   localparam int OTP_CTRL_SEC   = 1;

   // boot image
   localparam logic [31:0] CHECK_SKIP  = 32'h0D15_AB1E;
   localparam logic [31:0] CRC_POLY    = 32'hEDB8_8320;
   localparam logic [31:0] CRC_PRESET  = 32'hFFFF_FFFF;
   localparam int RAM_AW = 15;
   localparam logic [14:0] RAM_BASE = 15'h0000;

   typedef enum logic [3:0] {
      ST_HOLD, ST_DELAY, ST_SEC_REQ, ST_SEC_WAIT, ST_SIZE, ST_PROG,
      ST_CHECK, ST_VERIFY, ST_RUN, ST_HALT
   } tbsl_state_type;
endpackage : tbsl_pkg

/* File: rtl/tbsl_crc_if.sv */
// Purpose: carries the byte stream from loader to crc engine
// Assumes: one byte per cycle at most
// Notes:   value is the running crc before inversion
`timescale 1ns/10ps
interface tbsl_crc_if;
   logic        init;
   logic        feed;
   logic [7:0]  data;
   logic [31:0] value;
   modport src (output init, output feed, output data, input value);
   modport eng (input init, input feed, input data, output value);
endinterface : tbsl_crc_if

/* File: rtl/tbsl_crc.sv */
// Purpose: byte-wide reflected crc-32 engine
// Assumes: init and feed never in the same cycle
// Notes:   output is the raw remainder, caller inverts
`timescale 1ns/10ps
module tbsl_crc
   import tbsl_pkg::*;
(
   input  wire logic clock,
   input  wire logic rst,
   tbsl_crc_if.eng   crc
);
   logic [31:0] crc_q;
   logic [31:0] crc_d;

   always_comb begin
      crc_d = crc_q ^ {24'h00_0000, crc.data};
      for (int i = 0; i < 8; i++) begin
         crc_d = crc_d[0] ? ((crc_d >> 1) ^ CRC_POLY) : (crc_d >> 1);
      end
   end

   always_ff @(posedge clock) begin
      if (rst || crc.init) begin
         crc_q <= CRC_PRESET;
      end else if (crc.feed) begin
         crc_q <= crc_d;
      end
   end

   assign crc.value = crc_q;
endmodule : tbsl_crc

/* File: rtl/tbsl_top.sv */
// Purpose: tile reset release, security load, boot image loading, pll settings
// Assumes: image bytes arrive on one stream, source picked by boot_from_otp
// Notes:   registers on Avalon-MM, one wait cycle per access
// Summary of operation
// - tile clock ratio from feedback, input, post dividers
// - multiplier resets to post 1, feedback 63, input 0
// - multiplier settings rewritable at run time
// - reset pin low holds reset, pull-downs on
// - boot starts delay after reset pin release
// - security bit 5 picks otp, else flash
// - image is count, program words, check word
// - magic check word skips crc verification
// - count and check word assembled lsb first
// - program loaded at ram base, run there
// - crc covers count bytes and program bytes
// - reflected crc-32 polynomial edb88320
// - crc preset all ones, result inverted
// - security register loaded from otp before boot
// - otp content copied to sram, four 512-row sectors
// - otp programmed through address, data, control ports
// - bits 0 and 1 block test port, link
// - bit 5 bypasses boot rom, otp address 0
// - bit 7 redundant rows, bits 8-11 sector locks
// - bit 12 master lock, bit 13 test-otp block
// - bits 21:15 software field, 31:22 user id
//
// The register offsets and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
module tbsl_top
   import tbsl_pkg::*;
(
   input  wire logic                 clock,
   input  wire logic                 rst,
   input  wire logic                 rst_n_pin,
   output logic                      gpio_pulldown_en,
   // avalon-mm slave
   input  wire logic [5:0]           avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [31:0]          avs_writedata,
   input  wire logic [3:0]           avs_byteenable,
   output logic [31:0]               avs_readdata,
   output logic                      avs_waitrequest,
   // pll settings
   output logic [PLL_IN_W-1:0]       pll_input_div,
   output logic [PLL_FB_W-1:0]       pll_feedback,
   output logic [PLL_POST_W-1:0]     post_divider_setting,
   output logic [12:0]               pll_ratio_num,
   output logic [12:0]               pll_ratio_den,
   // otp row read, used for the security word
   output logic                      otp_rd_req,
   output logic [15:0]               otp_rd_addr,
   input  wire logic                 otp_rd_valid,
   input  wire logic [31:0]          otp_rd_data,
   // otp programming ports
   output logic                      otp_prog_strobe,
   output logic [15:0]               otp_prog_addr,
   output logic [31:0]               otp_prog_data,
   output logic [15:0]               otp_prog_ctrl,
   // boot image stream
   output logic                      boot_from_otp,
   output logic                      img_start,
   input  wire logic                 img_valid,
   input  wire logic [7:0]           img_data,
   output logic                      img_ready,
   // ram load port and processor start
   output logic                      ram_we,
   output logic [RAM_AW-1:0]         ram_addr,
   output logic [31:0]               ram_wdata,
   output logic                      cpu_run,
   output logic [RAM_AW-1:0]         cpu_start_addr,
   // security controls
   output logic                      test_port_block,
   output logic                      link_access_block,
   output logic                      otp_redundant_en,
   output logic [OTP_SECTORS-1:0]    otp_sector_inhibit,
   output logic                      otp_master_lock,
   output logic                      test_otp_block,
   output logic [6:0]                sec_gp_field,
   output logic [9:0]                user_code_ext
);
   tbsl_crc_if crc_bus ();

   tbsl_crc u_crc (
      .clock (clock),
      .rst   (rst),
      .crc   (crc_bus.eng)
   );

   // reset pin synchroniser
   logic           pin_s1_q;
   logic           pin_s2_q;
   logic           pin_s3_q;
   logic           pin_level_q;
   logic           hold;

   always_ff @(posedge clock) begin
      if (rst) begin
         pin_s1_q    <= 1'b0;
         pin_s2_q    <= 1'b0;
         pin_s3_q    <= 1'b0;
         pin_level_q <= 1'b0;
      end else begin
         pin_s1_q <= rst_n_pin;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         if (pin_s2_q == pin_s3_q) begin
            pin_level_q <= pin_s3_q;
         end
      end
   end

   assign hold             = ~pin_level_q;
   assign gpio_pulldown_en = hold;

   // bus handshake
   logic           ack_q;
   logic           req;
   logic           wr_go;
   logic [31:0]    rdata_q;
   logic [31:0]    rdata_d;
   logic [31:0]    bmask;

   assign req             = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_q;
   assign wr_go           = avs_write & ack_q;
   assign avs_readdata    = rdata_q;
   assign bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   always_ff @(posedge clock) begin
      if (rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   // pll settings
   logic [31:0]    pll_q;
   logic [31:0]    pll_w;

   assign pll_w = (pll_q & ~bmask) | (avs_writedata & bmask);

   always_ff @(posedge clock) begin
      if (rst) begin
         pll_q <= 32'h0000_0000;
         pll_q[PLL_IN_LSB +: PLL_IN_W]     <= PLL_IN_RST;
         pll_q[PLL_FB_LSB +: PLL_FB_W]     <= PLL_FB_RST;
         pll_q[PLL_POST_LSB +: PLL_POST_W] <= PLL_POST_RST;
      end else if (wr_go && avs_address == REG_PLL_CFG) begin
         pll_q <= 32'h0000_0000;
         pll_q[PLL_IN_LSB +: PLL_IN_W]     <= pll_w[PLL_IN_LSB +: PLL_IN_W];
         pll_q[PLL_FB_LSB +: PLL_FB_W]     <= pll_w[PLL_FB_LSB +: PLL_FB_W];
         pll_q[PLL_POST_LSB +: PLL_POST_W] <= pll_w[PLL_POST_LSB +: PLL_POST_W];
      end
   end

   assign pll_input_div        = pll_q[PLL_IN_LSB +: PLL_IN_W];
   assign pll_feedback         = pll_q[PLL_FB_LSB +: PLL_FB_W];
   assign post_divider_setting = pll_q[PLL_POST_LSB +: PLL_POST_W];

   // tile clock = osc * num / den, out-of-range settings are software's concern
   logic [12:0]    num_q;
   logic [12:0]    den_q;

   always_ff @(posedge clock) begin
      if (rst) begin
         num_q <= 13'h0000;
         den_q <= 13'h0001;
      end else begin
         num_q <= {1'b0, pll_feedback} + 13'h0001;
         den_q <= 13'((({7'h00, pll_input_div} + 13'h0001)
                  * ({10'h000, post_divider_setting} + 13'h0001)) << 1);
      end
   end

   assign pll_ratio_num = num_q;
   assign pll_ratio_den = den_q;

   // boot sequencer
   tbsl_state_type state_q;
   logic [DLY_W-1:0] dly_q;
   logic [31:0]    sec_q;
   logic [31:0]    size_q;
   logic [31:0]    check_q;
   logic [31:0]    word_q;
   logic [31:0]    left_q;
   logic [1:0]     bidx_q;
   logic [RAM_AW-1:0] waddr_q;
   logic           take;
   logic           crc_ok_q;
   logic           skip_q;
   logic [31:0]    crc_res;

   assign img_ready = (state_q == ST_SIZE) || (state_q == ST_PROG) || (state_q == ST_CHECK);
   assign take      = img_valid & img_ready;
   assign crc_res   = ~crc_bus.value;

   assign crc_bus.init = (state_q == ST_SEC_WAIT) && otp_rd_valid;
   assign crc_bus.feed = take && (state_q != ST_CHECK);
   assign crc_bus.data = img_data;

   always_ff @(posedge clock) begin
      if (rst || hold) begin
         state_q <= ST_HOLD;
         dly_q   <= '0;
      end else begin
         unique case (state_q)
            ST_HOLD: begin
               state_q <= ST_DELAY;
               dly_q   <= '0;
            end
            ST_DELAY: begin
               dly_q <= dly_q + 1'b1;
               if (dly_q == DLY_W'(BOOT_DELAY_CYC - 1)) begin
                  state_q <= ST_SEC_REQ;
               end
            end
            ST_SEC_REQ: state_q <= ST_SEC_WAIT;
            ST_SEC_WAIT: begin
               if (otp_rd_valid) begin
                  state_q <= ST_SIZE;
               end
            end
            ST_SIZE: begin
               if (take && bidx_q == 2'd3) begin
                  state_q <= ({img_data, word_q[31:8]} == 32'h0) ? ST_CHECK : ST_PROG;
               end
            end
            ST_PROG: begin
               if (take && bidx_q == 2'd3 && left_q == 32'h1) begin
                  state_q <= ST_CHECK;
               end
            end
            ST_CHECK: begin
               if (take && bidx_q == 2'd3) begin
                  state_q <= ST_VERIFY;
               end
            end
            ST_VERIFY: state_q <= (skip_q || crc_ok_q) ? ST_RUN : ST_HALT;
            ST_RUN:  state_q <= ST_RUN;
            ST_HALT: state_q <= ST_HALT;
         endcase
      end
   end

   // byte gathering, lsb first
   always_ff @(posedge clock) begin
      if (rst || hold || state_q == ST_SEC_WAIT) begin
         word_q <= 32'h0;
         bidx_q <= 2'd0;
      end else if (take) begin
         word_q <= {img_data, word_q[31:8]};
         bidx_q <= bidx_q + 2'd1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst || hold) begin
         size_q  <= 32'h0;
         left_q  <= 32'h0;
         check_q <= 32'h0;
         waddr_q <= RAM_BASE;
      end else if (take && bidx_q == 2'd3) begin
         unique case (state_q)
            ST_SIZE: begin
               size_q <= {img_data, word_q[31:8]};
               left_q <= {img_data, word_q[31:8]};
            end
            ST_PROG: begin
               left_q  <= left_q - 32'h1;
               waddr_q <= waddr_q + 1'b1;
            end
            ST_CHECK: check_q <= {img_data, word_q[31:8]};
            default: ;
         endcase
      end
   end

   // program word to ram from the base upward
   always_ff @(posedge clock) begin
      if (rst) begin
         ram_we    <= 1'b0;
         ram_addr  <= RAM_BASE;
         ram_wdata <= 32'h0;
      end else begin
         ram_we <= take && bidx_q == 2'd3 && state_q == ST_PROG;
         if (take && bidx_q == 2'd3 && state_q == ST_PROG) begin
            ram_addr  <= waddr_q;
            ram_wdata <= {img_data, word_q[31:8]};
         end
      end
   end

   // verdict captured once the check word is complete
   always_ff @(posedge clock) begin
      if (rst || hold) begin
         crc_ok_q <= 1'b0;
         skip_q   <= 1'b0;
      end else if (state_q == ST_CHECK && take && bidx_q == 2'd3) begin
         skip_q   <= {img_data, word_q[31:8]} == CHECK_SKIP;
         crc_ok_q <= {img_data, word_q[31:8]} == crc_res;
      end
   end

   assign cpu_run        = state_q == ST_RUN;
   assign cpu_start_addr = RAM_BASE;
   assign img_start      = state_q == ST_SEC_WAIT && otp_rd_valid;
   assign boot_from_otp  = sec_q[SEC_OTP_BOOT];
   assign otp_rd_req     = state_q == ST_SEC_REQ;
   assign otp_rd_addr    = OTP_SEC_ROW;

   // otp programming ports and security register
   logic [15:0]    oaddr_q;
   logic [31:0]    odata_q;
   logic [15:0]    octrl_q;
   logic           strobe_q;
   logic           refused_q;
   logic [1:0]     sector;
   logic           row_ok;
   logic           ctrl_wr;

   assign sector  = oaddr_q[OTP_ROW_W +: 2];
   assign row_ok  = ~sec_q[SEC_MASTER_LOCK] & ~sec_q[SEC_LOCK_LSB + sector];
   assign ctrl_wr = wr_go && avs_address == REG_OTP_CTRL;

   always_ff @(posedge clock) begin
      if (rst) begin
         oaddr_q <= 16'h0000;
         odata_q <= 32'h0000_0000;
         octrl_q <= 16'h0000;
      end else if (wr_go) begin
         if (avs_address == REG_OTP_ADDR) oaddr_q <= avs_writedata[15:0];
         if (avs_address == REG_OTP_DATA) odata_q <= avs_writedata;
         if (ctrl_wr) octrl_q <= avs_writedata[15:0];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         strobe_q  <= 1'b0;
         refused_q <= 1'b0;
      end else begin
         strobe_q <= ctrl_wr && avs_writedata[OTP_CTRL_ROW] && row_ok;
         if (ctrl_wr) begin
            refused_q <= (avs_writedata[OTP_CTRL_ROW] && !row_ok)
                      || (avs_writedata[OTP_CTRL_SEC] && sec_q[SEC_MASTER_LOCK]);
         end
      end
   end

   assign otp_prog_strobe = strobe_q;
   assign otp_prog_addr   = oaddr_q;
   assign otp_prog_data   = odata_q;
   assign otp_prog_ctrl   = octrl_q;

   always_ff @(posedge clock) begin
      if (rst) begin
         sec_q <= SEC_RST;
      end else if (state_q == ST_SEC_WAIT && otp_rd_valid) begin
         sec_q <= otp_rd_data;
      end else if (ctrl_wr && avs_writedata[OTP_CTRL_SEC] && !sec_q[SEC_MASTER_LOCK]) begin
         sec_q <= sec_q | odata_q;
      end else if (wr_go && avs_address == REG_SECURITY) begin
         sec_q <= (sec_q & ~(SEC_SW_MASK & bmask)) | (avs_writedata & SEC_SW_MASK & bmask);
      end
   end

   assign test_port_block    = sec_q[SEC_NO_TEST];
   assign link_access_block  = sec_q[SEC_NO_LINK];
   assign otp_redundant_en   = sec_q[SEC_REDUNDANT];
   assign otp_sector_inhibit = sec_q[SEC_LOCK_LSB +: OTP_SECTORS];
   assign otp_master_lock    = sec_q[SEC_MASTER_LOCK];
   assign test_otp_block     = sec_q[SEC_NO_TEST_OTP];
   assign sec_gp_field       = sec_q[SEC_GP_MSB:SEC_GP_LSB];
   assign user_code_ext      = sec_q[SEC_UID_MSB:SEC_UID_LSB];

   // read mux
   always_comb begin
      rdata_d = 32'h0000_0000;
      unique case (avs_address)
         REG_PLL_CFG:  rdata_d = pll_q;
         REG_SECURITY: rdata_d = sec_q;
         REG_STATUS:   rdata_d = {22'h0, refused_q, skip_q, crc_ok_q,
                                  boot_from_otp, cpu_run, state_q == ST_HALT, state_q};
         REG_OTP_ADDR: rdata_d = {16'h0000, oaddr_q};
         REG_OTP_DATA: rdata_d = odata_q;
         REG_OTP_CTRL: rdata_d = {16'h0000, octrl_q};
         REG_CRC:      rdata_d = crc_res;
         REG_RATIO:    rdata_d = {3'h0, den_q, 3'h0, num_q};
         default:      rdata_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         rdata_q <= 32'h0000_0000;
      end else if (avs_read && !ack_q) begin
         rdata_q <= rdata_d;
      end
   end
endmodule : tbsl_top

/* File: dv/tbsl_properties.sv */
// Purpose: port assertions for the loader
// Assumes: one clock, synchronous reset
// Notes:   bound into every tbsl_top
`timescale 1ns/10ps
module tbsl_properties
   import tbsl_pkg::*;
(
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        rst_n_pin,
   input wire logic        gpio_pulldown_en,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic        avs_waitrequest,
   input wire logic [5:0]  pll_input_div,
   input wire logic [11:0] pll_feedback,
   input wire logic [2:0]  post_divider_setting,
   input wire logic [12:0] pll_ratio_num,
   input wire logic [12:0] pll_ratio_den,
   input wire logic        otp_rd_req,
   input wire logic        otp_rd_valid,
   input wire logic        otp_prog_strobe,
   input wire logic [15:0] otp_prog_addr,
   input wire logic        otp_master_lock,
   input wire logic [3:0]  otp_sector_inhibit,
   input wire logic        img_start,
   input wire logic        img_ready,
   input wire logic        ram_we,
   input wire logic [14:0] ram_addr,
   input wire logic        cpu_run,
   input wire logic [14:0] cpu_start_addr
);
   logic [10:0] up_q;
   logic        req_q;
   logic [14:0] wr_q;
   logic [12:0] den_w;
   logic        lock_w;
   assign den_w = 13'(2 * (pll_input_div + 1) * (post_divider_setting + 1));
   assign lock_w = otp_master_lock | otp_sector_inhibit[otp_prog_addr[10:9]];
   always_ff @(posedge clock) begin
      if (rst || !rst_n_pin) up_q <= 11'h000;
      else if (up_q != 11'h7FF) up_q <= up_q + 11'h001;
   end
   always_ff @(posedge clock) begin
      if (rst || !rst_n_pin) req_q <= 1'b0;
      else if (otp_rd_req) req_q <= 1'b1;
   end
   always_ff @(posedge clock) begin
      if (rst || img_start) wr_q <= '0;
      else if (ram_we) wr_q <= wr_q + 1'b1;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_one_wait;
      avs_waitrequest ##1 !avs_waitrequest;
   endsequence
   sequence s_start_src;
      img_start;
   endsequence
   AST_BUS_WAIT: assert property ($rose(avs_read || avs_write) |-> s_one_wait)
      else $error("bus wait");
   AST_RATIO_NUM: assert property (!$past(rst) |-> pll_ratio_num == $past(pll_feedback) + 13'h1)
      else $error("ratio num");
   AST_RATIO_DEN: assert property (!$past(rst) |-> pll_ratio_den == $past(den_w))
      else $error("ratio den");
   AST_PLL_RESET: assert property ($fell(rst) |-> pll_input_div == 6'h00
      && pll_feedback == 12'h03F && post_divider_setting == 3'h1)
      else $error("pll reset");
   AST_PULLDOWN: assert property (!rst_n_pin [*6] |-> gpio_pulldown_en)
      else $error("pull-down off");
   AST_BOOT_EARLY: assert property (otp_rd_req |-> up_q >= BOOT_DELAY_CYC)
      else $error("boot early");
   AST_BOOT_LATE: assert property (up_q == 11'h5F0 |-> req_q)
      else $error("boot late");
   AST_SEC_FIRST: assert property (otp_rd_valid |-> s_start_src)
      else $error("no image start");
   AST_RAM_ORDER: assert property (ram_we |-> ram_addr == wr_q)
      else $error("ram address");
   AST_WORD_PULSE: assert property (ram_we |=> !ram_we)
      else $error("ram_we width");
   AST_RUN_BASE: assert property (cpu_run |-> cpu_start_addr == RAM_BASE && !img_ready)
      else $error("run");
   AST_PROG_LOCK: assert property (otp_prog_strobe |-> !$past(lock_w))
      else $error("locked program");
endmodule : tbsl_properties

bind tbsl_top tbsl_properties tbsl_properties_i (.*);

/* File: dv/tbsl_boot_src.sv */
// Purpose: boot flash and otp row model
// Assumes: bench loads an image before each boot
// Notes:   stalls at random, scrambles data when idle
`timescale 1ns/10ps
module tbsl_boot_src (
   input  wire logic        clock,
   input  wire logic        otp_rd_req,
   output logic             otp_rd_valid,
   output logic [31:0]      otp_rd_data,
   input  wire logic        img_start,
   output logic             img_valid,
   output logic [7:0]       img_data,
   input  wire logic        img_ready,
   input  wire logic [31:0] sec_word
);
   logic [7:0] img_q[$];
   int         pos = 0;
   int         lat = 0;
   int         seed = 2;
   task automatic load(input logic [7:0] b[$]);
      img_q = b;
      pos = b.size();
   endtask : load
   always @(posedge clock) begin
      otp_rd_valid <= (lat == 1);
      otp_rd_data <= (lat == 1) ? sec_word : ~otp_rd_data;
      if (otp_rd_req) lat = 2 + ($random(seed) & 3);
      else if (lat > 0) lat = lat - 1;
   end
   always @(posedge clock) begin
      if (img_start) pos = 0;
      else if (img_valid && img_ready) pos = pos + 1;
      if (img_valid && !img_ready) img_valid <= 1'b1;
      else if (pos < img_q.size() && ($random(seed) & 3) != 0) begin
         img_valid <= 1'b1;
         img_data <= img_q[pos];
      end else begin
         img_valid <= 1'b0;
         img_data <= ~img_data;
      end
   end
endmodule : tbsl_boot_src

/* File: dv/tbsl_tb_top.sv */
// Purpose: self-checking bench for the loader
// Assumes: fixed seed, one clock
// Notes:   pll, three boots, security field, otp locks
`timescale 1ns/10ps
module tbsl_tb_top
   import tbsl_pkg::*;
;
   logic clock, rst, rst_n_pin, gpio_pulldown_en, avs_read, avs_write, avs_waitrequest;
   logic otp_rd_req, otp_rd_valid, otp_prog_strobe, boot_from_otp, img_start, img_valid;
   logic img_ready, ram_we, cpu_run, test_port_block, link_access_block, otp_redundant_en;
   logic otp_master_lock, test_otp_block;
   logic [3:0]  avs_byteenable, otp_sector_inhibit;
   logic [5:0]  avs_address, pll_input_div;
   logic [11:0] pll_feedback;
   logic [2:0]  post_divider_setting;
   logic [12:0] pll_ratio_num, pll_ratio_den;
   logic [31:0] avs_writedata, avs_readdata, otp_rd_data, otp_prog_data, ram_wdata, q, d;
   logic [15:0] otp_rd_addr, otp_prog_addr, otp_prog_ctrl;
   logic [7:0]  img_data;
   logic [14:0] ram_addr, cpu_start_addr;
   logic [6:0]  sec_gp_field;
   logic [9:0]  user_code_ext;
   logic [31:0] sec_word, ram_m[0:15];
   int          bad_count = 0;
   int          samples_checked = 0;
   int          seed = 2;
   int          strobes = 0;
   tbsl_top tbsl_top_i (.*);
   tbsl_boot_src tbsl_boot_src_i (.*);
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      if (ram_we) ram_m[ram_addr[3:0]] = ram_wdata;
      if (otp_prog_strobe) strobes = strobes + 1;
   end
   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
      c = c ^ {24'h0, b};
      for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 32'hEDB8_8320 : c >> 1;
      return c;
   endfunction : crc_byte
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %h vs %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd);
      int n = 0;
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n >= 40) begin
         bad_count++;
         finish_test();
      end
   endtask : bus
   task automatic boot(input int mode, input int nw);
      logic [7:0]  b[$];
      logic [31:0] w[8];
      logic [31:0] crc;
      int          n;
      sec_word = ($random(seed) & 32'hFFFF_EEDF) | 32'h0400 | (mode == 1 ? 32'h20 : 32'h0);
      foreach (w[i]) w[i] = $random(seed);
      for (int i = 0; i < 4 + 4 * nw; i++)
         b.push_back(i < 4 ? 8'(nw >> (8 * i)) : w[(i - 4) / 4][8 * (i % 4) +: 8]);
      crc = 32'hFFFF_FFFF;
      foreach (b[i]) crc = crc_byte(crc, b[i]);
      crc = mode == 0 ? 32'h0D15_AB1E : ~crc ^ (mode == 2 ? 32'h1 : 32'h0);
      for (int i = 0; i < 4; i++) b.push_back(crc[8 * i +: 8]);
      tbsl_boot_src_i.load(b);
      ram_m = '{default: 'x};
      @(posedge clock);
      rst_n_pin <= 1'b0;
      repeat (8) @(posedge clock);
      chk(gpio_pulldown_en, 1'b1);
      rst_n_pin <= 1'b1;
      n = 0;
      do begin
         bus(0, REG_STATUS, 0);
         n++;
      end while (q[5:4] === 2'b00 && n < 900);
      if (n >= 900) begin
         bad_count++;
         finish_test();
      end
      chk(q[6:4], {mode == 1, mode != 2, mode == 2});
      chk(q[8], mode == 0);
      chk(cpu_run, mode != 2);
      chk(boot_from_otp, mode == 1);
      chk({user_code_ext, sec_gp_field, 1'b0, test_otp_block, otp_master_lock,
         otp_sector_inhibit, otp_redundant_en, 1'b0, boot_from_otp, 3'h0,
         link_access_block, test_port_block}, sec_word & 32'hFFFF_BFA3);
      bus(0, REG_SECURITY, 0);
      chk(q, sec_word);
      if (mode != 2) for (int i = 0; i < nw; i++) chk(ram_m[i], w[i]);
      $display("boot %0d done", mode);
   endtask : boot
   initial begin
      rst = 1'b1;
      rst_n_pin = 1'b0;
      avs_address = 6'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      sec_word = 32'h0;
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      bus(0, REG_PLL_CFG, 0);
      chk(q, 32'h0010_3F00);
      chk(pll_ratio_num, 32'h40);
      chk(pll_ratio_den, 32'h4);
      for (int i = 0; i < 5; i++) begin
         d = i == 0 ? 32'h007F_FF3F : $random(seed) & 32'h007F_FF3F;
         bus(1, REG_PLL_CFG, d);
         bus(0, REG_PLL_CFG, 0);
         chk(q, d);
         chk(pll_ratio_num, d[19:8] + 1);
         chk(pll_ratio_den, 2 * (d[5:0] + 1) * (d[22:20] + 1));
      end
      bus(0, 6'h20, 0);
      chk(q, 32'h0);
      $display("pll done");
      boot(0, 3);
      boot(1, 8);
      boot(2, 0);
      bus(1, REG_SECURITY, 32'hFFFF_FFFF);
      bus(0, REG_SECURITY, 0);
      chk(q, sec_word | 32'h003F_8000);
      bus(1, REG_SECURITY, 32'h0);
      bus(0, REG_SECURITY, 0);
      chk(q, sec_word & 32'hFFC0_7FFF);
      strobes = 0;
      bus(1, REG_OTP_ADDR, 32'h0400);
      bus(1, REG_OTP_CTRL, 32'h1);
      bus(0, REG_STATUS, 0);
      chk(q[9], 1'b1);
      bus(1, REG_OTP_ADDR, 32'h0);
      bus(1, REG_OTP_CTRL, 32'h1);
      bus(1, REG_OTP_DATA, 32'h1000);
      bus(1, REG_OTP_CTRL, 32'h3);
      bus(0, REG_STATUS, 0);
      chk(strobes, 2);
      chk(otp_master_lock, 1'b1);
      bus(1, REG_OTP_CTRL, 32'h1);
      bus(0, REG_STATUS, 0);
      chk(strobes, 2);
      $display("otp done");
      finish_test();
   end
endmodule : tbsl_tb_top
